// file: hw/ccp_pkg.sv
// Constants, types and helpers of the configuration command parser
package ccp_pkg;
    // ----------------------------------------------------------------
    // Characters
    // ----------------------------------------------------------------
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_QM = 8'h3f;
    localparam logic [7:0] CH_C  = 8'h43;
    localparam logic [7:0] CH_P  = 8'h50;
    localparam logic [7:0] CH_R  = 8'h52;
    localparam logic [7:0] CH_A  = 8'h41;
    localparam logic [7:0] CH_S  = 8'h53;
    localparam logic [7:0] CH_TU = 8'h54;
    localparam logic [7:0] CH_TL = 8'h74;
    localparam logic [7:0] CH_EU = 8'h45;
    localparam logic [7:0] CH_EL = 8'h65;

    // ----------------------------------------------------------------
    // Lengths, codes, timing
    // ----------------------------------------------------------------
    localparam int         BUF_DEPTH   = 22;
    localparam logic [4:0] LEN_CLR     = 5'h01;
    localparam logic [4:0] LEN_SER     = 5'h09;
    localparam logic [4:0] LEN_CANP    = 5'h03;
    localparam logic [4:0] LEN_CANT    = 5'h14;
    localparam logic [4:0] LEN_CHK     = 5'h02;
    localparam logic [3:0] BAUD_MAX    = 4'h0c;
    localparam logic [3:0] BAUD_MAX_X  = 4'h0e;
    localparam logic [3:0] CAN_MAX     = 4'h09;
    localparam logic [2:0] ERR_HDR     = 3'h1;
    localparam logic [2:0] ERR_LEN     = 3'h2;
    localparam logic [2:0] ERR_CHK     = 3'h3;
    localparam logic [2:0] ERR_TMO     = 3'h5;
    localparam int         CLK_KHZ     = 100_000;
    localparam int         TIMEOUT_MS  = 100;
    localparam int         TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;

    // ----------------------------------------------------------------
    // Register map (byte offsets) and reset values
    // ----------------------------------------------------------------
    localparam logic [4:0]  OFS_SER    = 5'h00;
    localparam logic [4:0]  OFS_CAN    = 5'h04;
    localparam logic [4:0]  OFS_MATCH  = 5'h08;
    localparam logic [4:0]  OFS_CARE   = 5'h0c;
    localparam logic [4:0]  OFS_STAT   = 5'h10;
    localparam logic [10:0] SER_RST    = 11'h437;
    localparam logic [4:0]  CAN_RST    = 5'h04;
    localparam logic [31:0] FILT_RST   = 32'h0000_0000;

    typedef struct packed {
        logic       err_resp;
        logic       chk_en;
        logic [1:0] parity;
        logic       stop2;
        logic [1:0] dbits;
        logic [3:0] baud;
    } ccp_ser_cfg_t;

    typedef enum logic [2:0] {
        ACT_NONE, ACT_CLR, ACT_SER_P, ACT_SER_T, ACT_CAN_P, ACT_CAN_T, ACT_OTHER
    } ccp_act_t;

    // Returns {valid, value} of one hex character, either case
    function automatic logic [4:0] ccp_hex(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            return {1'b1, c[3:0]};
        end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
            return {1'b1, 4'(c[3:0] + 4'h9)};
        end
        return 5'h00;
    endfunction : ccp_hex

    function automatic logic [7:0] ccp_asc(input logic [3:0] n);
        return (n < 4'ha) ? 8'(8'h30 + n) : 8'(8'h37 + n);
    endfunction : ccp_asc
endpackage : ccp_pkg

// file: hw/ccp_reply_if.sv
// Handshake between the parser and its error reply sender
`timescale 1ns/1ns
`default_nettype none
interface ccp_reply_if;
    logic       req;
    logic [2:0] code;
    logic       chk_en;
    logic       busy;
    modport src (output req, output code, output chk_en, input busy);
    modport snk (input req, input code, input chk_en, output busy);
endinterface : ccp_reply_if
`default_nettype wire

// file: hw/ccp_reply_tx.sv
// Error reply sender: question mark, code digit, optional checksum, CR
`timescale 1ns/1ns
`default_nettype none
module ccp_reply_tx (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    ccp_reply_if.snk        rp,
    output logic      [7:0] tx_data_out,
    output logic            tx_valid_out,
    input  wire logic       tx_ready_in
);
    logic       act_q,  next_act;
    logic [2:0] step_q, next_step;
    logic [7:0] byte_q, next_byte;
    logic [2:0] code_q, next_code;
    logic       chk_q,  next_chk;
    logic [7:0] sum;

    // ----------------------------------------------------------------
    // Sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_act  = act_q;
        next_step = step_q;
        next_byte = byte_q;
        next_code = code_q;
        next_chk  = chk_q;
        sum       = 8'(ccp_pkg::CH_QM + 8'h30 + {5'h00, code_q});
        if (!act_q) begin
            if (rp.req) begin
                next_act  = 1'b1;
                next_step = 3'h0;
                next_byte = ccp_pkg::CH_QM;
                next_code = rp.code;
                next_chk  = rp.chk_en;
            end
        end else if (tx_ready_in) begin
            if (step_q == 3'h4) begin
                next_act = 1'b0;
            end else begin
                // Checksum pair only in checksum mode
                next_step = (step_q == 3'h1 && !chk_q) ? 3'h4 : 3'(step_q + 3'h1);
                case (next_step)
                    3'h1:    next_byte = 8'(8'h30 + {5'h00, code_q});
                    3'h2:    next_byte = ccp_pkg::ccp_asc(sum[7:4]);
                    3'h3:    next_byte = ccp_pkg::ccp_asc(sum[3:0]);
                    default: next_byte = ccp_pkg::CH_CR;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            act_q  <= 1'b0;
            step_q <= 3'h0;
            byte_q <= 8'h00;
            code_q <= 3'h0;
            chk_q  <= 1'b0;
        end else begin
            act_q  <= next_act;
            step_q <= next_step;
            byte_q <= next_byte;
            code_q <= next_code;
            chk_q  <= next_chk;
        end
    end

    assign rp.busy      = act_q;
    assign tx_valid_out = act_q;
    assign tx_data_out  = byte_q;
endmodule : ccp_reply_tx
`default_nettype wire

// file: hw/ccp_parser.sv
// Configuration command parser top with its register slave
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Clear command clears error flags and lamp
// - Error reply is ?, code, [checksum], CR
// - Error replies only while error response enabled
// - Serial setup fields: baud, data, stop, parity, checksum, errors
// - Data field 0..3 selects five to eight bits
// - Stop field 0 one, 1 two stop bits
// - Parity field 0 none, 1 odd, 2 even
// - Checksum field 0 off, 1 on
// - Error response field 0 off, 1 on
// - Baud codes 00..0C select 110..230400 bit/s
// - Baud codes 0D, 0E optional per variant
// - Persistent serial setup stores, then restarts
// - Persistent CAN rate stores code, then reboots
// - Persistent CAN rate rejects user-defined code A
// - Temporary serial setup applies without storing
// - CAN setup: format, rate, match, care pattern
// - Temporary CAN setup applies without storing
// - Checksum is low byte of character sum, hex
// - Error codes 1 header, 2 length, 3 checksum, 5 timeout
module ccp_parser #(
    parameter int   TIMEOUT_CYC = ccp_pkg::TIMEOUT_CYC,
    parameter logic EXT_BAUD    = 1'b0
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_valid_in,
    output logic      [7:0]  tx_data_out,
    output logic             tx_valid_out,
    input  wire logic        tx_ready_in,
    input  wire logic        fifo_ovf_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    output logic      [10:0] ser_cfg_out,
    output logic             ser_apply_out,
    output logic      [3:0]  can_rate_out,
    output logic             can_ext_out,
    output logic      [31:0] filter_match_value_out,
    output logic      [31:0] filter_care_pattern_out,
    output logic             can_apply_out,
    output logic             nv_store_ser_out,
    output logic             nv_store_can_out,
    output logic             restart_out,
    output logic             clear_flags_out,
    output logic             fault_lamp_out,
    output logic             other_cmd_out
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_RECV = 3'b001, ST_EXEC = 3'b011,
        ST_STORE = 3'b010, ST_RST = 3'b110
    } ccp_st_t;

    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    ccp_st_t              state_q, next_state;
    logic [4:0]           cnt_q, next_cnt;
    logic                 ovf_q, next_ovf;
    logic                 tmo_q, next_tmo;
    logic [7:0]           sum_q, next_sum;
    logic [TW-1:0]        tcnt_q, next_tcnt;
    logic [7:0]           buf_q [ccp_pkg::BUF_DEPTH];
    logic [4:0]           h [ccp_pkg::BUF_DEPTH];
    ccp_pkg::ccp_ser_cfg_t ser_q, next_ser;
    logic [4:0]           can_q, next_can;
    logic [31:0]          match_q, next_match, care_q, next_care;
    logic                 lamp_q, next_lamp;
    logic [2:0]           lerr_q, next_lerr;
    logic                 sap_q, next_sap, cap_q, next_cap;
    logic                 ack_q;
    logic [31:0]          rdata_q, rd_mux, wmask, wval;
    logic                 buf_we, wr_go;
    ccp_pkg::ccp_act_t    e_act;
    logic [2:0]           e_err;
    logic [4:0]           pay, need, ia, ib;
    logic [7:0]           calc, c0;
    logic                 isp, other, fld_ok, hex_ok;
    logic [31:0]          e_match, e_care;
    ccp_reply_if          rpi ();

    // ----------------------------------------------------------------
    // Character capture
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < ccp_pkg::BUF_DEPTH; i++) begin : g_hex
            assign h[i] = ccp_pkg::ccp_hex(buf_q[i]);
        end
    endgenerate

    assign buf_we = rx_valid_in && rx_data_in != ccp_pkg::CH_CR && !ovf_q
                    && cnt_q < 5'(ccp_pkg::BUF_DEPTH)
                    && (state_q == ST_IDLE || state_q == ST_RECV);

    // Payload store holds data only, so it needs no reset
    always_ff @(posedge ref_clk_in) begin
        if (buf_we) begin
            buf_q[cnt_q] <= rx_data_in;
        end
    end

    always_comb begin
        next_state = state_q;
        next_cnt   = cnt_q;
        next_ovf   = ovf_q;
        next_tmo   = tmo_q;
        next_sum   = sum_q;
        next_tcnt  = tcnt_q;
        case (state_q)
            ST_IDLE, ST_RECV: begin
                if (rx_valid_in) begin
                    next_tcnt = '0;
                    if (rx_data_in == ccp_pkg::CH_CR) begin
                        next_state = ST_EXEC;
                    end else begin
                        next_state = ST_RECV;
                        next_sum   = 8'(sum_q + rx_data_in);
                        if (buf_we) begin
                            next_cnt = 5'(cnt_q + 5'h01);
                        end else begin
                            next_ovf = 1'b1;
                        end
                    end
                end else if (state_q == ST_RECV) begin
                    if (tcnt_q == TW'(TIMEOUT_CYC - 1)) begin
                        next_tmo   = 1'b1;
                        next_state = ST_EXEC;
                    end else begin
                        next_tcnt = TW'(tcnt_q + 1'b1);
                    end
                end
            end
            ST_EXEC: begin
                next_state = (e_act == ccp_pkg::ACT_SER_P || e_act == ccp_pkg::ACT_CAN_P)
                             ? ST_STORE : ST_IDLE;
            end
            ST_STORE: next_state = ST_RST;
            default:  next_state = ST_IDLE;
        endcase
        if (next_state == ST_IDLE && state_q != ST_IDLE) begin
            next_cnt  = 5'h00;
            next_ovf  = 1'b0;
            next_tmo  = 1'b0;
            next_sum  = 8'h00;
            next_tcnt = '0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
            ovf_q   <= 1'b0;
            tmo_q   <= 1'b0;
            sum_q   <= 8'h00;
            tcnt_q  <= '0;
        end else begin
            state_q <= next_state;
            cnt_q   <= next_cnt;
            ovf_q   <= next_ovf;
            tmo_q   <= next_tmo;
            sum_q   <= next_sum;
            tcnt_q  <= next_tcnt;
        end
    end

    // ----------------------------------------------------------------
    // Command evaluation, valid from the CR until back in idle
    // ----------------------------------------------------------------
    always_comb begin
        c0     = buf_q[0];
        pay    = ser_q.chk_en ? 5'(cnt_q - ccp_pkg::LEN_CHK) : cnt_q;
        isp    = cnt_q >= 5'h02 && c0 == ccp_pkg::CH_P && h[1][4] && h[1][3:0] <= 4'h3;
        other  = c0 == ccp_pkg::CH_TL || c0 == ccp_pkg::CH_TU || c0 == ccp_pkg::CH_EL
                 || c0 == ccp_pkg::CH_EU || c0 == ccp_pkg::CH_S
                 || (cnt_q >= 5'h02 && c0 == ccp_pkg::CH_R && buf_q[1] == ccp_pkg::CH_A);
        ia     = (cnt_q < 5'h02) ? 5'h00 : 5'(cnt_q - 5'h02);
        ib     = (cnt_q < 5'h02) ? 5'h00 : 5'(cnt_q - 5'h01);
        calc   = 8'(sum_q - buf_q[ia] - buf_q[ib]);
        hex_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            e_match[31-4*i -: 4] = h[4+i][3:0];
            e_care[31-4*i -: 4]  = h[12+i][3:0];
            hex_ok = hex_ok && h[4+i][4] && h[12+i][4];
        end
        need   = 5'h00;
        fld_ok = 1'b0;
        e_act  = ccp_pkg::ACT_NONE;
        if (c0 == ccp_pkg::CH_C) begin
            need   = ccp_pkg::LEN_CLR;
            fld_ok = 1'b1;
            e_act  = ccp_pkg::ACT_CLR;
        end else if (isp && !h[1][0]) begin
            need   = ccp_pkg::LEN_SER;
            e_act  = h[1][1] ? ccp_pkg::ACT_SER_T : ccp_pkg::ACT_SER_P;
            fld_ok = h[2] == 5'h10 && h[3][4]
                     && h[3][3:0] <= (EXT_BAUD ? ccp_pkg::BAUD_MAX_X : ccp_pkg::BAUD_MAX)
                     && h[4][4] && h[4][3:0] <= 4'h3
                     && h[5][4] && h[5][3:0] <= 4'h1
                     && h[6][4] && h[6][3:0] <= 4'h2
                     && h[7][4] && h[7][3:0] <= 4'h1
                     && h[8][4] && h[8][3:0] <= 4'h1;
        end else if (isp && h[1][1:0] == 2'h1) begin
            need   = ccp_pkg::LEN_CANP;
            e_act  = ccp_pkg::ACT_CAN_P;
            fld_ok = h[2][4] && h[2][3:0] <= ccp_pkg::CAN_MAX;
        end else if (isp) begin
            need   = ccp_pkg::LEN_CANT;
            e_act  = ccp_pkg::ACT_CAN_T;
            fld_ok = h[2][4] && h[2][3:0] <= 4'h1 && h[3][4]
                     && h[3][3:0] <= ccp_pkg::CAN_MAX && hex_ok;
        end
        e_err = 3'h0;
        if (tmo_q) begin
            e_err = ccp_pkg::ERR_TMO;
        end else if (cnt_q == 5'h00 || !(c0 == ccp_pkg::CH_C || isp || other)
                     || (isp && e_act == ccp_pkg::ACT_NONE)) begin
            e_err = ccp_pkg::ERR_HDR;
        end else if (other) begin
            e_act = ccp_pkg::ACT_OTHER;
        end else if (ovf_q || (ser_q.chk_en && cnt_q < 5'h02) || pay != need) begin
            e_err = ccp_pkg::ERR_LEN;
        end else if (ser_q.chk_en && !(h[ia][4] && h[ib][4]
                     && {h[ia][3:0], h[ib][3:0]} == calc)) begin
            e_err = ccp_pkg::ERR_CHK;
        end else if (!fld_ok) begin
            e_err = ccp_pkg::ERR_LEN;
        end
        if (e_err != 3'h0) begin
            e_act = ccp_pkg::ACT_NONE;
        end
    end

    // ----------------------------------------------------------------
    // Settings, lamp and register slave
    // ----------------------------------------------------------------
    assign wr_go = avs_write_in && ack_q;
    assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

    always_comb begin
        case (avs_address_in)
            ccp_pkg::OFS_SER:   rd_mux = {21'h00_0000, ser_q};
            ccp_pkg::OFS_CAN:   rd_mux = {27'h000_0000, can_q};
            ccp_pkg::OFS_MATCH: rd_mux = match_q;
            ccp_pkg::OFS_CARE:  rd_mux = care_q;
            ccp_pkg::OFS_STAT:  rd_mux = {27'h000_0000, rpi.busy, lamp_q, lerr_q};
            default:            rd_mux = 32'h0000_0000;
        endcase
        wval       = (rd_mux & ~wmask) | (avs_writedata_in & wmask);
        next_ser   = ser_q;
        next_can   = can_q;
        next_match = match_q;
        next_care  = care_q;
        next_lerr  = lerr_q;
        next_sap   = 1'b0;
        next_cap   = 1'b0;
        if (wr_go) begin
            case (avs_address_in)
                ccp_pkg::OFS_SER:   begin next_ser = wval[10:0]; next_sap = 1'b1; end
                ccp_pkg::OFS_CAN:   begin next_can = wval[4:0];  next_cap = 1'b1; end
                ccp_pkg::OFS_MATCH: begin next_match = wval; next_cap = 1'b1; end
                ccp_pkg::OFS_CARE:  begin next_care  = wval; next_cap = 1'b1; end
                default:            ;
            endcase
        end
        // Command wins over a bus write
        if (state_q == ST_EXEC) begin
            if (e_err != 3'h0) begin
                next_lerr = e_err;
            end
            if (e_act == ccp_pkg::ACT_SER_P || e_act == ccp_pkg::ACT_SER_T) begin
                next_ser = {h[8][0], h[7][0], h[6][1:0], h[5][0], h[4][1:0], h[3][3:0]};
                next_sap = 1'b1;
            end
            if (e_act == ccp_pkg::ACT_CAN_P) begin
                next_can = {can_q[4], h[2][3:0]};
                next_cap = 1'b1;
            end
            if (e_act == ccp_pkg::ACT_CAN_T) begin
                next_can   = {h[2][0], h[3][3:0]};
                next_match = e_match;
                next_care  = e_care;
                next_cap   = 1'b1;
            end
        end
        // Overflow wins over a clear
        next_lamp = fifo_ovf_in ? 1'b1
                  : (state_q == ST_EXEC && e_act == ccp_pkg::ACT_CLR) ? 1'b0 : lamp_q;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ser_q   <= ccp_pkg::SER_RST;
            can_q   <= ccp_pkg::CAN_RST;
            match_q <= ccp_pkg::FILT_RST;
            care_q  <= ccp_pkg::FILT_RST;
            lamp_q  <= 1'b0;
            lerr_q  <= 3'h0;
            sap_q   <= 1'b0;
            cap_q   <= 1'b0;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ser_q   <= next_ser;
            can_q   <= next_can;
            match_q <= next_match;
            care_q  <= next_care;
            lamp_q  <= next_lamp;
            lerr_q  <= next_lerr;
            sap_q   <= next_sap;
            cap_q   <= next_cap;
            ack_q   <= (avs_read_in || avs_write_in) && !ack_q;
            rdata_q <= (avs_read_in && !ack_q) ? rd_mux : rdata_q;
        end
    end

    // ----------------------------------------------------------------
    // Error reply and outputs
    // ----------------------------------------------------------------
    // A reply in flight drops a new one
    assign rpi.req    = state_q == ST_EXEC && e_err != 3'h0 && ser_q.err_resp;
    assign rpi.code   = e_err;
    assign rpi.chk_en = ser_q.chk_en;

    ccp_reply_tx u_reply (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .rp           (rpi.snk),
        .tx_data_out  (tx_data_out),
        .tx_valid_out (tx_valid_out),
        .tx_ready_in  (tx_ready_in)
    );

    assign avs_waitrequest_out     = (avs_read_in || avs_write_in) && !ack_q;
    assign avs_readdata_out        = rdata_q;
    assign ser_cfg_out             = ser_q;
    assign ser_apply_out           = sap_q;
    assign can_rate_out            = can_q[3:0];
    assign can_ext_out             = can_q[4];
    assign filter_match_value_out  = match_q;
    assign filter_care_pattern_out = care_q;
    assign can_apply_out           = cap_q;
    assign nv_store_ser_out        = state_q == ST_STORE && !h[1][0];
    assign nv_store_can_out        = state_q == ST_STORE && h[1][0];
    assign restart_out             = state_q == ST_RST;
    assign clear_flags_out         = state_q == ST_EXEC && e_act == ccp_pkg::ACT_CLR;
    assign fault_lamp_out          = lamp_q;
    assign other_cmd_out           = state_q == ST_EXEC && e_act == ccp_pkg::ACT_OTHER;
endmodule : ccp_parser
`default_nettype wire

// file: dv/ccp_parser_chk.sv
// Assertions on the ports of the configuration command parser
`timescale 1ns/1ns
`default_nettype none
module ccp_parser_chk (
    input wire logic        ref_clk_in,
    input wire logic        rst_b_in,
    input wire logic [7:0]  tx_data_out,
    input wire logic        tx_valid_out,
    input wire logic        tx_ready_in,
    input wire logic        fifo_ovf_in,
    input wire logic        avs_read_in,
    input wire logic        avs_waitrequest_out,
    input wire logic [10:0] ser_cfg_out,
    input wire logic        ser_apply_out,
    input wire logic [3:0]  can_rate_out,
    input wire logic        can_apply_out,
    input wire logic        nv_store_ser_out,
    input wire logic        nv_store_can_out,
    input wire logic        restart_out,
    input wire logic        fault_lamp_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    ser_store_a: assert property (nv_store_ser_out |=> restart_out) else $error("no restart");
    can_store_a: assert property (nv_store_can_out |=> restart_out) else $error("no reboot");
    restart_cause_a: assert property (restart_out |-> $past(nv_store_ser_out | nv_store_can_out))
        else $error("stray restart");
    reply_head_a: assert property ($rose(tx_valid_out) |-> tx_data_out == ccp_pkg::CH_QM)
        else $error("reply head wrong");
    reply_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
        else $error("reply not held");
    lamp_set_a: assert property (fifo_ovf_in |=> fault_lamp_out) else $error("lamp not lit");
    baud_lim_a: assert property (ser_apply_out |-> ser_cfg_out[3:0] <= ccp_pkg::BAUD_MAX)
        else $error("bad baud");
    parity_lim_a: assert property (ser_apply_out |-> ser_cfg_out[8:7] != 2'h3) else $error("bad parity");
    can_lim_a: assert property (can_apply_out |-> can_rate_out <= ccp_pkg::CAN_MAX)
        else $error("bad can rate");
    bus_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("bad wait");
endmodule : ccp_parser_chk
bind ccp_parser ccp_parser_chk u_chk (.*);
`default_nettype wire

// file: dv/ccp_host_model.sv
// Host model: takes reply characters with random stalls
`timescale 1ns/1ns
`default_nettype none
module ccp_host_model (
    input  wire logic ref_clk_in,
    output logic      tx_ready_out
);
    int seed = 18;
    // Stalls exercise the hold
    always @(posedge ref_clk_in) tx_ready_out <= ($random(seed) % 3) != 0;
endmodule : ccp_host_model
`default_nettype wire

// file: dv/ccp_parser_tb.sv
// Self-checking bench of the configuration command parser
`timescale 1ns/1ns
`default_nettype none
module ccp_parser_tb;
    logic clk = 0, rst_b = 0, rxv = 0, ovf = 0, rd = 0, wr = 0, rdy, txv, wq, cext, sap, cap, nss;
    logic nsc, rso, clr, lamp, oth;
    logic [7:0] rxd = 0, txd, exp_q[$];
    logic [4:0] adr = 0;
    logic [31:0] wd = 0, rdat, fm, fc, v, w;
    logic [10:0] scfg, es;
    logic [3:0] crate;
    int bad_count = 0, num_checks = 0, seed = 18, cm = 0, n_clr = 0, n_ss = 0, n_sc = 0, i, b, d, s, p;
    always #5 clk = ~clk;
    ccp_parser #(.TIMEOUT_CYC(50)) dut (.ref_clk_in(clk), .rst_b_in(rst_b), .rx_data_in(rxd),
        .rx_valid_in(rxv), .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(rdy),
        .fifo_ovf_in(ovf), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wq), .ser_cfg_out(scfg), .ser_apply_out(sap), .can_rate_out(crate),
        .can_ext_out(cext), .filter_match_value_out(fm), .filter_care_pattern_out(fc),
        .can_apply_out(cap), .nv_store_ser_out(nss), .nv_store_can_out(nsc), .restart_out(rso),
        .clear_flags_out(clr), .fault_lamp_out(lamp), .other_cmd_out(oth));
    ccp_host_model host (.ref_clk_in(clk), .tx_ready_out(rdy));
    task automatic check(input string nm, input logic [71:0] seen, input logic [71:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value %s: expected %h seen %h", nm, want, seen);
        end
    endtask : check
    task automatic final_report;
        if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
    endfunction : hx
    task automatic put(input logic [7:0] c);
        rxd <= c;
        rxv <= 1'b1;
        @(posedge clk);
        rxv <= 1'b0;
        @(posedge clk);
    endtask : put
    task automatic cmd(input string t, input bit tmo = 0);
        logic [7:0] sm = 0;
        foreach (t[k]) begin
            put(t[k]);
            sm += t[k];
        end
        if (cm != 0) begin
            put(hx(sm[7:4]));
            put(hx(sm[3:0]));
        end
        if (!tmo) put(8'h0d);
        repeat (80) @(posedge clk);
    endtask : cmd
    task automatic er(input logic [7:0] c);
        logic [7:0] sm = 8'h3f + 8'h30 + c;
        exp_q.push_back(8'h3f);
        exp_q.push_back(8'h30 + c);
        if (cm != 0) exp_q.push_back(hx(sm[7:4]));
        if (cm != 0) exp_q.push_back(hx(sm[3:0]));
        exp_q.push_back(8'h0d);
    endtask : er
    task automatic av(input logic [4:0] a, input logic wn, output logic [31:0] r);
        adr <= a;
        rd <= !wn;
        wr <= wn;
        wd <= $random(seed);
        do @(posedge clk); while (wq !== 1'b0);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : av
    always @(posedge clk) begin
        n_clr += (clr === 1'b1);
        n_ss += (nss === 1'b1);
        n_sc += (nsc === 1'b1);
        if (txv === 1'b1 && rdy === 1'b1) begin
            if (exp_q.size() != 0) check("reply", txd, exp_q.pop_front());
            else check("unexpected reply", 1, 0);
        end
    end
    initial begin
        #100_000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        av(ccp_pkg::OFS_SER, 1'b0, v);
        check("ser reg", v, 32'h0000_0437);
        for (i = 0; i < 6; i++) begin
            b = {$random(seed)} % 13;
            d = {$random(seed)} % 4;
            s = {$random(seed)} % 2;
            p = {$random(seed)} % 3;
            es = {2'b10, p[1:0], s[0], d[1:0], b[3:0]};
            cmd($sformatf("P%0d%02X%0d%0d%0d01", (i % 2) * 2, b, d, s, p));
            check("ser cfg", scfg, es);
            check("ser stores", n_ss, (i + 2) / 2);
        end
        for (i = 0; i < 10; i++) begin
            cmd($sformatf("P1%0d", i));
            check("can rate", crate, i);
        end
        er(2);
        cmd("P1A");
        check("can stores", n_sc, 10);
        v = $random(seed);
        w = $random(seed);
        cmd($sformatf("P316%08X%08X", v, w));
        check("can cfg", {fm, fc, crate, cext}, {v, w, 4'h6, 1'b1});
        check("can stores", n_sc, 10);
        er(1);
        cmd("X");
        er(1);
        cmd("P4");
        er(2);
        cmd("C1");
        er(5);
        cmd("C", 1);
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        cmd("C");
        check("clear", {lamp, n_clr}, {1'b0, 32'd1});
        cmd("P20730011");
        cm = 1;
        cmd("C");
        er(3);
        cm = 0;
        cmd("C00");
        cm = 1;
        cmd("P20730000");
        cm = 0;
        cmd("X");
        check("clear", n_clr, 2);
        av(5'h14, 1'b1, v);
        av(5'h14, 1'b0, v);
        check("unmapped", v, 0);
        av(ccp_pkg::OFS_SER, 1'b0, v);
        check("ser reg", v, 32'h0000_0037);
        check("replies left", exp_q.size(), 0);
        final_report();
    end
endmodule : ccp_parser_tb
`default_nettype wire
